// ### rtl/fsir_pkg.sv
// Purpose: Shared constants and carriers for the fault status and ident registers
// Assumes: 8-bit register data, 8-bit register addresses
// Notes:   Ident characters are parameters with arbitrary defaults
package fsir_pkg;

   // ==========================================================
   // Register offsets
   localparam logic [7:0] FSIR_OFS_PROT_STATUS = 8'h2E;
   localparam logic [7:0] FSIR_OFS_DIE_KIND    = 8'h39;
   localparam logic [7:0] FSIR_OFS_VAR_REV     = 8'h3A;

   // ==========================================================
   // Field positions in protection_event_status
   localparam int FSIR_BIT_OPEN_DIODE = 2;
   localparam int FSIR_BIT_THERMAL    = 1;
   localparam int FSIR_BIT_OVERVOLT   = 0;

   // ==========================================================
   // Reset values
   localparam logic       FSIR_RST_FLAG   = 1'b0;
   localparam logic [7:0] FSIR_RST_RDATA  = 8'h00;
   localparam logic [4:0] FSIR_RSVD_VALUE = 5'h00;

   // ==========================================================
   // Carriers
   typedef struct packed {
      logic       rd;
      logic [7:0] addr;
   } fsir_req_s;

   typedef struct packed {
      logic open_diode;
      logic thermal;
      logic overvolt;
   } fsir_evt_s;

endpackage

// ### rtl/fsir_sticky_flag.sv
// Purpose: One latched event flag, cleared by a finished status read
// Assumes: Event and clear synchronous to clk_sys
// Notes:   Set wins over clear so no event is lost
`timescale 1ns/1ps
module fsir_sticky_flag (
   // Clock and reset
   input  wire logic clk_sys,
   input  wire logic rst_n,
   // Control
   input  wire logic event_in,
   input  wire logic clear,
   // State
   output logic      flag_q
);

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         flag_q <= fsir_pkg::FSIR_RST_FLAG;
      end else if (event_in) begin
         flag_q <= 1'b1;
      end else if (clear) begin
         flag_q <= 1'b0;
      end
   end

endmodule

// ### rtl/fsir_regs.sv
// Purpose: Read-only protection status and die identification register group
// Assumes: Serial bus engine presents one-cycle read strobes with address
// Notes:   Read data registered; flags clear on the strobe that samples them
//
// Contract
// - Status bit 2 shows catch diode missing now, 0 when present.
// - Status bit 1 latches any thermal shutdown since last status read.
// - Status bit 0 latches any overvoltage event since last status read.
// - Status bits 7 to 3 are reserved and read zero.
// - Ident 0x39 returns die_kind_code code as two BCD characters.
// - Ident 0x3A returns variant character high, mask revision low.
`timescale 1ns/1ps
module fsir_regs #(
   parameter logic [3:0] DIE_KIND_HI  = 4'h1, // arbitrary
   parameter logic [3:0] DIE_KIND_LO  = 4'h2, // arbitrary
   parameter logic [3:0] VARIANT_DIG  = 4'h3, // arbitrary
   parameter logic [3:0] MASK_REVISION_CODE_DIG = 4'h4  // arbitrary
) (
   // Clock and reset
   input  wire logic                clk_sys,
   input  wire logic                nrst,
   // Register read port
   input  wire fsir_pkg::fsir_req_s req,
   output logic [7:0]               rdata_q,
   // Protection events
   input  wire fsir_pkg::fsir_evt_s evt
);

   // ==========================================================
   // Reset release
   // Asserts at once, releases on a clean edge through two stages
   logic nrst_s1_q;
   logic nrst_sync_q;

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         nrst_s1_q   <= 1'b0;
         nrst_sync_q <= 1'b0;
      end else begin
         nrst_s1_q   <= 1'b1;
         nrst_sync_q <= nrst_s1_q;
      end
   end

   // ==========================================================
   // Decode
   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      hit = (a == ofs);
   endfunction

   // Everything outside the three offsets reads back zero
   function automatic logic mapped(input logic [7:0] a);
      mapped = hit(a, fsir_pkg::FSIR_OFS_PROT_STATUS)
            || hit(a, fsir_pkg::FSIR_OFS_DIE_KIND)
            || hit(a, fsir_pkg::FSIR_OFS_VAR_REV);
   endfunction

   logic status_rd;
   logic die_kind_rd;
   logic var_rev_rd;
   assign status_rd   = req.rd && hit(req.addr, fsir_pkg::FSIR_OFS_PROT_STATUS);
   assign die_kind_rd = req.rd && hit(req.addr, fsir_pkg::FSIR_OFS_DIE_KIND);
   assign var_rev_rd  = req.rd && hit(req.addr, fsir_pkg::FSIR_OFS_VAR_REV);

   // ==========================================================
   // Identification characters
   // Build-time constants; a new mask changes only these
   logic [7:0] die_kind_code;
   logic [3:0] variant_digit;
   logic [3:0] mask_revision_code;

   assign die_kind_code      = {DIE_KIND_HI, DIE_KIND_LO};
   assign variant_digit      = VARIANT_DIG;
   assign mask_revision_code = MASK_REVISION_CODE_DIG;

   // ==========================================================
   // Latched flags
   logic thermal_trip_flag;
   logic output_overvolt_flag;

   fsir_sticky_flag u_thermal (
      .clk_sys  (clk_sys),
      .rst_n    (nrst_sync_q),
      .event_in (evt.thermal),
      .clear    (status_rd),
      .flag_q   (thermal_trip_flag)
   );

   fsir_sticky_flag u_overvolt (
      .clk_sys  (clk_sys),
      .rst_n    (nrst_sync_q),
      .event_in (evt.overvolt),
      .clear    (status_rd),
      .flag_q   (output_overvolt_flag)
   );

   // Live level, never latched, so a refitted diode shows at once
   logic open_catch_diode_flag;
   assign open_catch_diode_flag = evt.open_diode;

   // Diode bit live; an event in the read cycle also shows in the data
   logic [7:0] status_val;
   always_comb begin
      status_val = {fsir_pkg::FSIR_RSVD_VALUE, 3'h0};
      status_val[fsir_pkg::FSIR_BIT_OPEN_DIODE] = open_catch_diode_flag;
      status_val[fsir_pkg::FSIR_BIT_THERMAL]    = thermal_trip_flag | evt.thermal;
      status_val[fsir_pkg::FSIR_BIT_OVERVOLT]   = output_overvolt_flag | evt.overvolt;
   end

   // ==========================================================
   // Read data
   always_ff @(posedge clk_sys or negedge nrst_sync_q) begin
      if (!nrst_sync_q) begin
         rdata_q <= fsir_pkg::FSIR_RST_RDATA;
      end else if (req.rd) begin
         case (req.addr)
            fsir_pkg::FSIR_OFS_PROT_STATUS: rdata_q <= status_val;
            fsir_pkg::FSIR_OFS_DIE_KIND:    rdata_q <= die_kind_code;
            fsir_pkg::FSIR_OFS_VAR_REV:     rdata_q <= {variant_digit, mask_revision_code};
            default:                        rdata_q <= fsir_pkg::FSIR_RST_RDATA;
         endcase
      end
   end

   // ==========================================================
   // Checks: status bits
   diode_live_a: assert property (
      @(posedge clk_sys) disable iff (!nrst_sync_q)
      status_rd |=> rdata_q[fsir_pkg::FSIR_BIT_OPEN_DIODE] == $past(open_catch_diode_flag))
      else $error("diode bit not live");

   reserved_zero_a: assert property (
      @(posedge clk_sys) disable iff (!nrst_sync_q)
      status_rd |=> rdata_q[7:3] == fsir_pkg::FSIR_RSVD_VALUE)
      else $error("reserved bits nonzero");

   thermal_read_a: assert property (
      @(posedge clk_sys) disable iff (!nrst_sync_q)
      (status_rd && thermal_trip_flag) |=> rdata_q[fsir_pkg::FSIR_BIT_THERMAL])
      else $error("thermal flag lost on read");

   overvolt_read_a: assert property (
      @(posedge clk_sys) disable iff (!nrst_sync_q)
      (status_rd && output_overvolt_flag) |=> rdata_q[fsir_pkg::FSIR_BIT_OVERVOLT])
      else $error("overvolt flag lost on read");

   thermal_quiet_a: assert property (
      @(posedge clk_sys) disable iff (!nrst_sync_q)
      (status_rd && !thermal_trip_flag && !evt.thermal) |=> !rdata_q[fsir_pkg::FSIR_BIT_THERMAL])
      else $error("thermal bit set without event");

   overvolt_quiet_a: assert property (
      @(posedge clk_sys) disable iff (!nrst_sync_q)
      (status_rd && !output_overvolt_flag && !evt.overvolt)
      |=> !rdata_q[fsir_pkg::FSIR_BIT_OVERVOLT])
      else $error("overvolt bit set without event");

   // ==========================================================
   // Checks: latched flags
   // Set wins over clear, so the clear checks leave out events
   thermal_set_a: assert property (
      @(posedge clk_sys) disable iff (!nrst_sync_q)
      evt.thermal |=> thermal_trip_flag)
      else $error("thermal event not latched");

   overvolt_set_a: assert property (
      @(posedge clk_sys) disable iff (!nrst_sync_q)
      evt.overvolt |=> output_overvolt_flag)
      else $error("overvolt event not latched");

   read_clear_a: assert property (
      @(posedge clk_sys) disable iff (!nrst_sync_q)
      (status_rd && !evt.thermal && !evt.overvolt)
      |=> !thermal_trip_flag && !output_overvolt_flag)
      else $error("flags not cleared by read");

   hold_flag_a: assert property (
      @(posedge clk_sys) disable iff (!nrst_sync_q)
      (thermal_trip_flag && !status_rd) |=> thermal_trip_flag)
      else $error("thermal flag dropped without read");

   overvolt_hold_a: assert property (
      @(posedge clk_sys) disable iff (!nrst_sync_q)
      (output_overvolt_flag && !status_rd) |=> output_overvolt_flag)
      else $error("overvolt flag dropped without read");

   thermal_spur_a: assert property (
      @(posedge clk_sys) disable iff (!nrst_sync_q)
      (!thermal_trip_flag && !evt.thermal) |=> !thermal_trip_flag)
      else $error("thermal flag rose without event");

   overvolt_spur_a: assert property (
      @(posedge clk_sys) disable iff (!nrst_sync_q)
      (!output_overvolt_flag && !evt.overvolt) |=> !output_overvolt_flag)
      else $error("overvolt flag rose without event");

   // ==========================================================
   // Checks: identification
   die_kind_a: assert property (
      @(posedge clk_sys) disable iff (!nrst_sync_q)
      die_kind_rd |=> rdata_q == {DIE_KIND_HI, DIE_KIND_LO})
      else $error("die kind wrong");

   var_rev_a: assert property (
      @(posedge clk_sys) disable iff (!nrst_sync_q)
      var_rev_rd |=> rdata_q == {VARIANT_DIG, MASK_REVISION_CODE_DIG})
      else $error("variant revision wrong");

   ident_bcd_a: assert property (
      @(posedge clk_sys) disable iff (!nrst_sync_q)
      die_kind_rd |=> (rdata_q[7:4] <= 4'h9) && (rdata_q[3:0] <= 4'h9))
      else $error("die kind not BCD");

   // ==========================================================
   // Checks: read port
   unmapped_zero_a: assert property (
      @(posedge clk_sys) disable iff (!nrst_sync_q)
      (req.rd && !mapped(req.addr)) |=> rdata_q == fsir_pkg::FSIR_RST_RDATA)
      else $error("unmapped read not zero");

   rdata_hold_a: assert property (
      @(posedge clk_sys) disable iff (!nrst_sync_q)
      !req.rd |=> $stable(rdata_q))
      else $error("read data moved without read");

   // ==========================================================
   // Coverage of the main scenarios
   thermal_seen_c: cover property (
      @(posedge clk_sys) disable iff (!nrst_sync_q)
      evt.thermal ##[1:8] status_rd);
   overvolt_seen_c: cover property (
      @(posedge clk_sys) disable iff (!nrst_sync_q)
      evt.overvolt ##[1:8] status_rd);
   set_on_clear_c: cover property (
      @(posedge clk_sys) disable iff (!nrst_sync_q)
      status_rd && evt.thermal);
   ident_read_c: cover property (
      @(posedge clk_sys) disable iff (!nrst_sync_q)
      die_kind_rd);
   diode_read_c: cover property (
      @(posedge clk_sys) disable iff (!nrst_sync_q)
      status_rd && open_catch_diode_flag);

endmodule

// ### dv/fsir_host_model.sv
// Purpose: Host-side reader of the status and ident registers
// Assumes: One read strobe per register access
// Notes:   Idle address is inverted so a stale value never passes
`timescale 1ns/1ps
module fsir_host_model (
   // Clock
   input  wire logic          clk_sys,
   // Read port
   output fsir_pkg::fsir_req_s req,
   input  wire logic [7:0]    rdata_q
);
   initial begin
      req = '{rd: 1'b0, addr: 8'hFF};
   end

   // ==========================================================
   // One register read
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_sys);
      #1;
      req = '{rd: 1'b1, addr: a};
      @(posedge clk_sys);
      #1;
      d = rdata_q;
      req = '{rd: 1'b0, addr: ~a};
   endtask
endmodule

// ### dv/tb_fault_status_and_ident_regs.sv
// Purpose: Self-checking bench for the status and ident registers
// Assumes: Reads go through the host model, events driven directly
// Notes:   Ident characters overridden with arbitrary values
`timescale 1ns/1ps
module tb_fault_status_and_ident_regs;
   localparam logic [3:0] KH = 4'h5; // arbitrary
   localparam logic [3:0] KL = 4'h6; // arbitrary
   localparam logic [3:0] VD = 4'h8; // arbitrary
   localparam logic [3:0] MR = 4'h9; // arbitrary
   logic                clk_sys;
   logic                nrst;
   fsir_pkg::fsir_req_s req;
   fsir_pkg::fsir_evt_s evt;
   logic [7:0]          rdata_q;
   int                  error_cnt;
   int                  num_checks;

   fsir_regs #(.DIE_KIND_HI(KH), .DIE_KIND_LO(KL), .VARIANT_DIG(VD), .MASK_REVISION_CODE_DIG(MR))
      fsir_regs_i (.clk_sys(clk_sys), .nrst(nrst), .req(req), .rdata_q(rdata_q), .evt(evt));
   fsir_host_model fsir_host_model_i (.clk_sys(clk_sys), .req(req), .rdata_q(rdata_q));

   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end

   // ==========================================================
   // Helpers
   task automatic chk(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      fsir_host_model_i.rd(a, d);
      num_checks++;
      if (d !== exp) begin
         error_cnt++;
         $display("MISMATCH %0t addr %h got %h exp %h", $time, a, d, exp);
      end
   endtask

   // One-cycle thermal and overvoltage pulses
   task automatic pulse(input logic th, input logic ov);
      @(posedge clk_sys);
      #1;
      evt.thermal = th;
      evt.overvolt = ov;
      @(posedge clk_sys);
      #1;
      evt.thermal = 1'b0;
      evt.overvolt = 1'b0;
   endtask

   // ==========================================================
   // Scenarios
   task automatic t_ident();
      chk(8'h39, {KH, KL});
      chk(8'h3A, {VD, MR});
      chk(8'h2F, 8'h00);
   endtask

   task automatic t_sticky();
      pulse(1'b1, 1'b0);
      chk(8'h2E, 8'h02);
      chk(8'h2E, 8'h00);
      pulse(1'b1, 1'b1);
      chk(8'h2E, 8'h03);
      chk(8'h2E, 8'h00);
   endtask

   // Diode bit is live, so it survives reads
   task automatic t_diode();
      evt.open_diode = 1'b1;
      pulse(1'b0, 1'b1);
      chk(8'h2E, 8'h05);
      chk(8'h2E, 8'h04);
      evt.open_diode = 1'b0;
      pulse(1'b1, 1'b1);
      chk(8'h2E, 8'h03);
      chk(8'h2E, 8'h00);
   endtask

   // Event in the strobe cycle: set wins, so it is reported twice
   task automatic t_set_wins();
      fork
         chk(8'h2E, 8'h02);
         begin
            @(posedge clk_sys);
            #1;
            evt.thermal = 1'b1;
            @(posedge clk_sys);
            #1;
            evt.thermal = 1'b0;
         end
      join
      chk(8'h2E, 8'h02);
      chk(8'h2E, 8'h00);
   endtask

   // Mid-run reset drops pending flags and clears read data
   task automatic t_reset();
      chk(8'h39, {KH, KL});
      pulse(1'b1, 1'b1);
      @(posedge clk_sys);
      #1;
      nrst = 1'b0;
      @(posedge clk_sys);
      #1;
      num_checks++;
      if (rdata_q !== fsir_pkg::FSIR_RST_RDATA) begin
         error_cnt++;
         $display("MISMATCH %0t read data %h kept through reset", $time, rdata_q);
      end
      nrst = 1'b1;
      repeat (3) @(posedge clk_sys);
      chk(8'h2E, 8'h00);
   endtask

   task automatic conclude();
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // ==========================================================
   // Main sequence and watchdog
   initial begin
      evt = '0;
      nrst = 1'b0;
      error_cnt = 0;
      num_checks = 0;
      repeat (16) @(posedge clk_sys);
      #1;
      nrst = 1'b1;
      repeat (3) @(posedge clk_sys);
      t_ident();
      t_sticky();
      t_diode();
      t_set_wins();
      t_reset();
      conclude();
   end

   initial begin
      #200000;
      error_cnt++;
      conclude();
   end
endmodule
